// >>> rtl/pst_pkg.sv
// shared constants for the power-module status and telemetry bank
package pst_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR     = 8'h03;
    localparam logic [7:0] CMD_VOUT_FLG  = 8'h7a;
    localparam logic [7:0] CMD_IOUT_FLG  = 8'h7b;
    localparam logic [7:0] CMD_IN_FLG    = 8'h7c;
    localparam logic [7:0] CMD_HEAT_FLG  = 8'h7d;
    localparam logic [7:0] CMD_CML_FLG   = 8'h7e;
    localparam logic [7:0] CMD_VIN_RD    = 8'h88;
    localparam logic [7:0] CMD_VOUT_RD   = 8'h8b;
    localparam logic [7:0] CMD_IOUT_RD   = 8'h8c;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int         DATA_W        = 16;
    localparam int         MEAS_W        = 10;
    localparam int         SYNC_W        = 12;
    localparam int         LAT_W         = 10;
    localparam logic [7:0] FLAG_RST      = 8'h00;
    localparam logic [15:0] WORD_RST     = 16'h0000;

    // ------------------------------------------------------------
    // field positions inside the status bytes
    // ------------------------------------------------------------
    localparam int VO_OV   = 7;
    localparam int VO_UV   = 4;
    localparam int VO_LIM  = 3;
    localparam int VO_UNK  = 0;
    localparam int IO_OC   = 7;
    localparam int IO_OCUV = 6;
    localparam int IO_WARN = 5;
    localparam int IN_OVP  = 7;
    localparam int IN_OVW  = 6;
    localparam int IN_UVW  = 5;
    localparam int TM_OTF  = 7;
    localparam int TM_OTW  = 6;
    localparam int CM_CMD  = 7;
    localparam int CM_DATA = 6;
    localparam int CM_MEM  = 4;
    localparam int CM_OTH  = 1;
    localparam int CM_BUSY = 0;

    // ------------------------------------------------------------
    // index of each asynchronous condition in the synchroniser
    // ------------------------------------------------------------
    localparam int S_OUT_OV  = 0;
    localparam int S_OUT_UV  = 1;
    localparam int S_CUR     = 2;
    localparam int S_CUR_UV  = 3;
    localparam int S_IN_OVP  = 4;
    localparam int S_IN_OVW  = 5;
    localparam int S_IN_UVW  = 6;
    localparam int S_HEAT_F  = 7;
    localparam int S_HEAT_W  = 8;
    localparam int S_MISC    = 9;
    localparam int S_MEM_F   = 10;
    localparam int S_MEM_B   = 11;

    // ------------------------------------------------------------
    // index of each sticky flag in the latch bank
    // ------------------------------------------------------------
    localparam int L_IN_OVP  = 0;
    localparam int L_IN_OVW  = 1;
    localparam int L_IN_UVW  = 2;
    localparam int L_HEAT_F  = 3;
    localparam int L_HEAT_W  = 4;
    localparam int L_UNK     = 5;
    localparam int L_CMD     = 6;
    localparam int L_DATA    = 7;
    localparam int L_MEM     = 8;
    localparam int L_OTH     = 9;
endpackage

// >>> rtl/pst_latch_if.sv
// carrier between the top and its sticky flag bank
`timescale 1ns/1ps
`default_nettype none
interface pst_latch_if;
    logic [pst_pkg::LAT_W-1:0] set_cond;
    logic                      clr;
    logic [pst_pkg::LAT_W-1:0] flags;
    modport latch (input set_cond, input clr, output flags);
    modport user  (output set_cond, output clr, input flags);
endinterface
`default_nettype wire

// >>> rtl/pst_sync.sv
// two-flop synchroniser for the analog condition inputs
`timescale 1ns/1ps
`default_nettype none
module pst_sync (
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic [pst_pkg::SYNC_W-1:0] async_in,
    output logic      [pst_pkg::SYNC_W-1:0] sync_q
);
    logic [pst_pkg::SYNC_W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/pst_latch.sv
// bank of sticky flags: set by a condition, cleared by command once it is gone
`timescale 1ns/1ps
`default_nettype none
module pst_latch (
    input  wire logic    sys_clk,
    input  wire logic    resetn,
    pst_latch_if.latch   lif
);
    // a live condition keeps the flag set even through a clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lif.flags <= '0;
        end else begin
            lif.flags <= lif.set_cond | (lif.flags & ~{pst_pkg::LAT_W{lif.clr}});
        end
    end
endmodule
`default_nettype wire

// >>> rtl/pst_top.sv
// status and telemetry register bank of the power module
`timescale 1ns/1ps
`default_nettype none
module pst_top (
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic                       cmd_valid,
    input  wire logic                       cmd_write,
    input  wire logic [7:0]                 cmd_code,
    input  wire logic                       data_err,
    input  wire logic                       comm_err,
    input  wire logic                       out_ov_in,
    input  wire logic                       out_uv_in,
    input  wire logic                       cur_trip_in,
    input  wire logic                       cur_trip_uv_in,
    input  wire logic                       in_ov_pin_in,
    input  wire logic                       in_ov_warn_in,
    input  wire logic                       in_uv_warn_in,
    input  wire logic                       heat_fault_in,
    input  wire logic                       heat_warn_in,
    input  wire logic                       misc_fault_in,
    input  wire logic                       mem_fault_in,
    input  wire logic                       mem_busy_in,
    input  wire logic                       meas_valid,
    input  wire logic [pst_pkg::MEAS_W-1:0] vin_meas,
    input  wire logic [pst_pkg::MEAS_W-1:0] vout_meas,
    input  wire logic [pst_pkg::MEAS_W-1:0] iout_meas,
    input  wire logic [pst_pkg::MEAS_W-1:0] iout_warn_limit,
    input  wire logic                       setpoint_valid,
    input  wire logic [15:0]                setpoint_value,
    input  wire logic [15:0]                setpoint_max,
    input  wire logic [15:0]                setpoint_min,
    output logic                            rd_valid_q,
    output logic      [pst_pkg::DATA_W-1:0] rd_data_q
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic code_readable(input logic [7:0] c);
        return (c == pst_pkg::CMD_VOUT_FLG) || (c == pst_pkg::CMD_IOUT_FLG)
            || (c == pst_pkg::CMD_IN_FLG)   || (c == pst_pkg::CMD_HEAT_FLG)
            || (c == pst_pkg::CMD_CML_FLG)  || (c == pst_pkg::CMD_VIN_RD)
            || (c == pst_pkg::CMD_VOUT_RD)  || (c == pst_pkg::CMD_IOUT_RD);
    endfunction

    function automatic logic [pst_pkg::DATA_W-1:0] widen(
        input logic [pst_pkg::MEAS_W-1:0] v);
        return {{(pst_pkg::DATA_W - pst_pkg::MEAS_W){1'b0}}, v};
    endfunction

    // ------------------------------------------------------------
    // synchronised analog conditions
    // ------------------------------------------------------------
    logic [pst_pkg::SYNC_W-1:0] async_w;
    logic [pst_pkg::SYNC_W-1:0] sync_w;

    assign async_w = {mem_busy_in, mem_fault_in, misc_fault_in, heat_warn_in,
                      heat_fault_in, in_uv_warn_in, in_ov_warn_in, in_ov_pin_in,
                      cur_trip_uv_in, cur_trip_in, out_uv_in, out_ov_in};

    pst_sync u_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (async_w),
        .sync_q   (sync_w)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire logic rd_req_w   = cmd_valid & ~cmd_write;
    wire logic wr_req_w   = cmd_valid & cmd_write;
    wire logic readable_w = code_readable(cmd_code);
    wire logic clr_w      = wr_req_w & (cmd_code == pst_pkg::CMD_CLEAR);
    // unknown codes count as bad commands; writes to read-only codes as bad data
    wire logic bad_cmd_w  = cmd_valid & ~readable_w & ~clr_w;
    wire logic wr_ro_w    = wr_req_w & readable_w;

    // ------------------------------------------------------------
    // sticky flag bank
    // ------------------------------------------------------------
    pst_latch_if lif ();
    logic [pst_pkg::LAT_W-1:0] lat_w;

    always_comb begin
        lif.set_cond                   = '0;
        lif.set_cond[pst_pkg::L_IN_OVP] = sync_w[pst_pkg::S_IN_OVP];
        lif.set_cond[pst_pkg::L_IN_OVW] = sync_w[pst_pkg::S_IN_OVW];
        lif.set_cond[pst_pkg::L_IN_UVW] = sync_w[pst_pkg::S_IN_UVW];
        lif.set_cond[pst_pkg::L_HEAT_F] = sync_w[pst_pkg::S_HEAT_F];
        lif.set_cond[pst_pkg::L_HEAT_W] = sync_w[pst_pkg::S_HEAT_W];
        lif.set_cond[pst_pkg::L_UNK]    = sync_w[pst_pkg::S_MISC];
        lif.set_cond[pst_pkg::L_CMD]    = bad_cmd_w;
        lif.set_cond[pst_pkg::L_DATA]   = data_err | wr_ro_w;
        lif.set_cond[pst_pkg::L_MEM]    = sync_w[pst_pkg::S_MEM_F];
        lif.set_cond[pst_pkg::L_OTH]    = comm_err;
    end

    assign lif.clr = clr_w;
    assign lat_w   = lif.flags;

    pst_latch u_latch (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .lif     (lif)
    );

    // ------------------------------------------------------------
    // telemetry capture and setpoint check
    // ------------------------------------------------------------
    logic [pst_pkg::MEAS_W-1:0] vin_q;
    logic [pst_pkg::MEAS_W-1:0] vout_q;
    logic [pst_pkg::MEAS_W-1:0] iout_q;
    logic                       lim_q;

    // a reading is taken whole on the strobe so a word never mixes two samples
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vin_q  <= '0;
            vout_q <= '0;
            iout_q <= '0;
        end else if (meas_valid) begin
            vin_q  <= vin_meas;
            vout_q <= vout_meas;
            iout_q <= iout_meas;
        end
    end

    // live: reflects the most recent requested setpoint only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lim_q <= 1'b0;
        end else if (setpoint_valid) begin
            lim_q <= (setpoint_value > setpoint_max) | (setpoint_value < setpoint_min);
        end
    end

    wire logic warn_w = iout_q > iout_warn_limit;

    // ------------------------------------------------------------
    // status byte assembly
    // ------------------------------------------------------------
    logic [7:0] vout_flg_w;
    logic [7:0] iout_flg_w;
    logic [7:0] in_flg_w;
    logic [7:0] heat_flg_w;
    logic [7:0] cml_flg_w;

    always_comb begin
        vout_flg_w                    = pst_pkg::FLAG_RST;
        vout_flg_w[pst_pkg::VO_OV]    = sync_w[pst_pkg::S_OUT_OV];
        vout_flg_w[pst_pkg::VO_UV]    = sync_w[pst_pkg::S_OUT_UV];
        vout_flg_w[pst_pkg::VO_LIM]   = lim_q;
        vout_flg_w[pst_pkg::VO_UNK]   = lat_w[pst_pkg::L_UNK];
        iout_flg_w                    = pst_pkg::FLAG_RST;
        iout_flg_w[pst_pkg::IO_OC]    = sync_w[pst_pkg::S_CUR];
        iout_flg_w[pst_pkg::IO_OCUV]  = sync_w[pst_pkg::S_CUR_UV];
        iout_flg_w[pst_pkg::IO_WARN]  = warn_w;
        in_flg_w                      = pst_pkg::FLAG_RST;
        in_flg_w[pst_pkg::IN_OVP]     = lat_w[pst_pkg::L_IN_OVP];
        in_flg_w[pst_pkg::IN_OVW]     = lat_w[pst_pkg::L_IN_OVW];
        in_flg_w[pst_pkg::IN_UVW]     = lat_w[pst_pkg::L_IN_UVW];
        heat_flg_w                    = pst_pkg::FLAG_RST;
        heat_flg_w[pst_pkg::TM_OTF]   = lat_w[pst_pkg::L_HEAT_F];
        heat_flg_w[pst_pkg::TM_OTW]   = lat_w[pst_pkg::L_HEAT_W];
        cml_flg_w                     = pst_pkg::FLAG_RST;
        cml_flg_w[pst_pkg::CM_CMD]    = lat_w[pst_pkg::L_CMD];
        cml_flg_w[pst_pkg::CM_DATA]   = lat_w[pst_pkg::L_DATA];
        cml_flg_w[pst_pkg::CM_MEM]    = lat_w[pst_pkg::L_MEM];
        cml_flg_w[pst_pkg::CM_OTH]    = lat_w[pst_pkg::L_OTH];
        cml_flg_w[pst_pkg::CM_BUSY]   = sync_w[pst_pkg::S_MEM_B];
    end

    // ------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------
    logic [pst_pkg::DATA_W-1:0] rd_mux_w;

    always_comb begin
        case (cmd_code)
            pst_pkg::CMD_VOUT_FLG: rd_mux_w = {8'h00, vout_flg_w};
            pst_pkg::CMD_IOUT_FLG: rd_mux_w = {8'h00, iout_flg_w};
            pst_pkg::CMD_IN_FLG:   rd_mux_w = {8'h00, in_flg_w};
            pst_pkg::CMD_HEAT_FLG: rd_mux_w = {8'h00, heat_flg_w};
            pst_pkg::CMD_CML_FLG:  rd_mux_w = {8'h00, cml_flg_w};
            pst_pkg::CMD_VIN_RD:   rd_mux_w = widen(vin_q);
            pst_pkg::CMD_VOUT_RD:  rd_mux_w = widen(vout_q);
            pst_pkg::CMD_IOUT_RD:  rd_mux_w = widen(iout_q);
            default:               rd_mux_w = pst_pkg::WORD_RST;
        endcase
    end

    // writes never reach any storage here; CMD_CLEAR clears the sticky flags, any other write raises a comm flag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= pst_pkg::WORD_RST;
        end else begin
            rd_valid_q <= rd_req_w & readable_w;
            if (rd_req_w & readable_w) begin
                rd_data_q <= rd_mux_w;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    wire logic rd_vo_w = rd_req_w & (cmd_code == pst_pkg::CMD_VOUT_FLG);
    wire logic rd_io_w = rd_req_w & (cmd_code == pst_pkg::CMD_IOUT_FLG);
    wire logic rd_in_w = rd_req_w & (cmd_code == pst_pkg::CMD_IN_FLG);
    wire logic rd_tm_w = rd_req_w & (cmd_code == pst_pkg::CMD_HEAT_FLG);
    wire logic rd_ic_w = rd_req_w & (cmd_code == pst_pkg::CMD_IOUT_RD);

    out_ov_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_vo_w |=> rd_valid_q && rd_data_q[7] == $past(sync_w[pst_pkg::S_OUT_OV]))
        else $error("output over-voltage bit wrong on read");

    out_uv_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_vo_w |=> rd_data_q[4] == $past(sync_w[pst_pkg::S_OUT_UV]))
        else $error("output under-voltage bit wrong on read");

    setpoint_lim_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (setpoint_valid && (setpoint_value > setpoint_max || setpoint_value < setpoint_min))
            ##1 !setpoint_valid ##1 rd_vo_w
        |=> rd_data_q[pst_pkg::VO_LIM])
        else $error("setpoint limit bit not reported");

    // a clear one cycle later may drop the flag once the cause is gone
    unknown_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sync_w[pst_pkg::S_MISC] |=> lat_w[pst_pkg::L_UNK]
            ##1 (lat_w[pst_pkg::L_UNK] || $past(clr_w)))
        else $error("unknown fault bit not latched");

    meas_capture_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        meas_valid |=> vin_q == $past(vin_meas) && vout_q == $past(vout_meas))
        else $error("voltage reading not captured");

    cur_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_ic_w |=> rd_data_q == widen($past(iout_q)))
        else $error("current reading wrong or upper bits set");

    cur_warn_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_io_w |=> rd_data_q[5] == ($past(iout_q) > $past(iout_warn_limit)))
        else $error("current warning bit disagrees with threshold");

    in_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        lat_w[pst_pkg::L_IN_OVW] && !clr_w |=> lat_w[pst_pkg::L_IN_OVW])
        else $error("input flag dropped without clear");

    in_rsvd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_in_w |=> rd_data_q[4:0] == 5'h00)
        else $error("input reserved bits not zero");

    in_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_in_w |=> (rd_data_q[pst_pkg::IN_OVP] || !$past(sync_w[pst_pkg::S_IN_OVP], 2))
            && (rd_data_q[pst_pkg::IN_OVW] || !$past(sync_w[pst_pkg::S_IN_OVW], 2))
            && (rd_data_q[pst_pkg::IN_UVW] || !$past(sync_w[pst_pkg::S_IN_UVW], 2)))
        else $error("input flag not latched");

    heat_rsvd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_tm_w |=> rd_data_q[5:0] == 6'h00
            && rd_data_q[7] == $past(lat_w[pst_pkg::L_HEAT_F]))
        else $error("thermal byte wrong");

    heat_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clr_w && !sync_w[pst_pkg::S_HEAT_F] && !sync_w[pst_pkg::S_HEAT_W]
        |=> !lat_w[pst_pkg::L_HEAT_F] && !lat_w[pst_pkg::L_HEAT_W])
        else $error("thermal flags not cleared");

    write_ignored_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_req_w |=> !rd_valid_q && $stable(rd_data_q))
        else $error("write disturbed read data");

    bad_cmd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        bad_cmd_w |=> lat_w[pst_pkg::L_CMD] && !rd_valid_q)
        else $error("invalid command not flagged");

    cur_live_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_io_w |=> rd_data_q[pst_pkg::IO_OC] == $past(sync_w[pst_pkg::S_CUR])
            && rd_data_q[pst_pkg::IO_OCUV] == $past(sync_w[pst_pkg::S_CUR_UV]))
        else $error("current trip bits wrong on read");

    mem_busy_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_req_w && cmd_code == pst_pkg::CMD_CML_FLG
        |=> rd_data_q[pst_pkg::CM_BUSY] == $past(sync_w[pst_pkg::S_MEM_B]))
        else $error("memory busy bit wrong on read");

    read_answer_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_req_w && readable_w |=> rd_valid_q && rd_data_q[15:10] == 6'h00)
        else $error("read not answered or upper bits set");
endmodule
`default_nettype wire

// >>> verif/pst_host.sv
// host model that issues commands to the status bank and collects read answers
`timescale 1ns/1ps
`default_nettype none
module pst_host (
    input  wire logic                       sys_clk,
    output logic                            cmd_valid,
    output logic                            cmd_write,
    output logic      [7:0]                 cmd_code,
    input  wire logic                       rd_valid_q,
    input  wire logic [pst_pkg::DATA_W-1:0] rd_data_q
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
    end

    // one command for one edge; the answer stands in the cycle after it
    task automatic xfer(input logic wr, input logic [7:0] code, output logic ok,
                        output logic [pst_pkg::DATA_W-1:0] data);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        @(negedge sys_clk);
        ok        = rd_valid_q;
        data      = rd_data_q;
        cmd_valid = 1'b0;
        // released lines flip so a stale code never passes for a held one
        cmd_write = ~wr;
        cmd_code  = ~code;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the status and telemetry bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [11:0] c;
        logic [7:0]  code;
        logic [7:0]  exp;
        logic        stick;
    } pst_row_t;

    // condition bits: 0 out ov .. 11 mem busy, in port order
    localparam pst_row_t rows[12] = '{
        '{12'h001, 8'h7a, 8'h80, 1'b0}, '{12'h002, 8'h7a, 8'h10, 1'b0},
        '{12'h004, 8'h7b, 8'h80, 1'b0}, '{12'h008, 8'h7b, 8'h40, 1'b0},
        '{12'h010, 8'h7c, 8'h80, 1'b1}, '{12'h020, 8'h7c, 8'h40, 1'b1},
        '{12'h040, 8'h7c, 8'h20, 1'b1}, '{12'h080, 8'h7d, 8'h80, 1'b1},
        '{12'h100, 8'h7d, 8'h40, 1'b1}, '{12'h200, 8'h7a, 8'h01, 1'b1},
        '{12'h400, 8'h7e, 8'h10, 1'b1}, '{12'h800, 8'h7e, 8'h01, 1'b0}};
    localparam logic [7:0] codes[8] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h88, 8'h8b, 8'h8c};
    localparam logic [15:0] spv[4] = '{16'h0101, 16'h000f, 16'h0100, 16'h0010};
    localparam logic [15:0] spx[4] = '{16'h0008, 16'h0008, 16'h0000, 16'h0000};

    logic        sys_clk, resetn, data_err, comm_err, meas_valid, setpoint_valid;
    logic        cmd_valid, cmd_write, rd_valid_q;
    logic [7:0]  cmd_code;
    logic [11:0] cond;
    logic [9:0]  vin_meas, vout_meas, iout_meas, iout_warn_limit;
    logic [15:0] sp_val, sp_max, sp_min, rd_data_q;
    int          bad_count = 0;
    int          check_count = 0;

    pst_top uut (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .data_err(data_err), .comm_err(comm_err),
        .out_ov_in(cond[0]), .out_uv_in(cond[1]), .cur_trip_in(cond[2]),
        .cur_trip_uv_in(cond[3]), .in_ov_pin_in(cond[4]), .in_ov_warn_in(cond[5]),
        .in_uv_warn_in(cond[6]), .heat_fault_in(cond[7]), .heat_warn_in(cond[8]),
        .misc_fault_in(cond[9]), .mem_fault_in(cond[10]), .mem_busy_in(cond[11]),
        .meas_valid(meas_valid), .vin_meas(vin_meas), .vout_meas(vout_meas),
        .iout_meas(iout_meas), .iout_warn_limit(iout_warn_limit),
        .setpoint_valid(setpoint_valid), .setpoint_value(sp_val), .setpoint_max(sp_max),
        .setpoint_min(sp_min), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));

    pst_host host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input string name);
        logic        ok;
        logic [15:0] d;
        host.xfer(1'b0, code, ok, d);
        chk("read answered", {15'h0000, ok}, 16'h0001);
        chk(name, d, exp);
    endtask

    // write, clear or unmapped command: no answer may come back
    task automatic noans(input logic wr, input logic [7:0] code);
        logic        ok;
        logic [15:0] d;
        host.xfer(wr, code, ok, d);
        chk("no answer", {15'h0000, ok}, 16'h0000);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic pulse(input logic [3:0] m);
        @(negedge sys_clk);
        {comm_err, data_err, setpoint_valid, meas_valid} = m;
        @(negedge sys_clk);
        {comm_err, data_err, setpoint_valid, meas_valid} = 4'h0;
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        #500000;
        bad_count++;
        conclude;
    end

    initial begin
        resetn = 1'b0;
        cond = 12'h000;
        {comm_err, data_err, setpoint_valid, meas_valid} = 4'h0;
        {vin_meas, vout_meas, iout_meas, iout_warn_limit} = '0;
        {sp_val, sp_max, sp_min} = {16'h0000, 16'h0100, 16'h0010};
        idle(3);
        resetn = 1'b1;
        foreach (codes[i]) rd(codes[i], 16'h0000, "reset value");
        noans(1'b1, 8'h7a);
        rd(8'h7a, 16'h0000, "written status");
        noans(1'b0, 8'h55);
        pulse(4'h8);
        rd(8'h7e, 16'h00c2, "comm flags");
        noans(1'b1, 8'h03);
        rd(8'h7e, 16'h0000, "comm cleared");
        pulse(4'h4);
        noans(1'b1, 8'h55);
        rd(8'h7e, 16'h00c0, "data and unmapped write");
        noans(1'b1, 8'h03);
        foreach (rows[i]) begin
            cond = rows[i].c;
            idle(4);
            rd(rows[i].code, {8'h00, rows[i].exp}, "flag set");
            cond = 12'h000;
            idle(4);
            rd(rows[i].code, {8'h00, rows[i].stick ? rows[i].exp : 8'h00}, "removed");
            noans(1'b1, 8'h03);
            rd(rows[i].code, 16'h0000, "cleared");
        end
        // clear while the cause is still there must not drop the flag
        cond = 12'h100;
        idle(4);
        noans(1'b1, 8'h03);
        rd(8'h7d, 16'h0040, "clear too early");
        cond = 12'h000;
        idle(4);
        noans(1'b1, 8'h03);
        rd(8'h7d, 16'h0000, "late clear");
        {vin_meas, vout_meas, iout_meas, iout_warn_limit} = {10'h3ff, 10'h2aa, 10'h155, 10'h155};
        pulse(4'h1);
        rd(8'h88, 16'h03ff, "input volts");
        rd(8'h8b, 16'h02aa, "output volts");
        rd(8'h8c, 16'h0155, "output amps");
        rd(8'h7b, 16'h0000, "warn at limit");
        iout_meas = 10'h156;
        pulse(4'h1);
        rd(8'h7b, 16'h0020, "warn above limit");
        noans(1'b1, 8'h8c);
        rd(8'h8c, 16'h0156, "written reading");
        foreach (spv[i]) begin
            sp_val = spv[i];
            pulse(4'h2);
            rd(8'h7a, spx[i], "setpoint limit");
        end
        cond = 12'h010;
        idle(4);
        resetn = 1'b0;
        cond = 12'h000;
        idle(2);
        resetn = 1'b1;
        rd(8'h7c, 16'h0000, "mid-run reset");
        rd(8'h8c, 16'h0000, "reading reset");
        conclude;
    end
endmodule
`default_nettype wire
